/* File: hw_break_unit.sv */
// Hardware break unit: combines detector hits and exceptions into a delayed halt.
// Assumes the target bus and exception pulses are on clk_i; host writes then applies.
module hw_break_unit
    import brk_pkg::*;
(
    input  wire logic                   clk_i,       // Bus-cycle clock.
    input  wire logic                   sys_rst_i,   // Synchronous reset.
    input  wire logic                   bus_cyc_i,   // Valid bus cycle.
    input  wire logic                   bus_fetch_i, // Instruction fetch cycle.
    input  wire logic [ADDR_W-1:0]      bus_addr_i,  // Cycle address.
    input  wire logic                   int_ack_i,   // Interrupt acknowledge.
    input  wire logic                   trig_pin_i,  // External trigger pin.
    input  wire logic [EXC_N-1:0]       exc_i,       // Exception event pulses.
    input  wire logic                   det_we_i,    // Write detector criteria.
    input  wire logic [IDX_W-1:0]       det_idx_i,   // Detector index.
    input  wire kind_t                  det_kind_i,  // Detector kind.
    input  wire logic [ADDR_W-1:0]      det_addr_i,  // Detector address.
    input  wire logic [ADDR_W-1:0]      det_mask_i,  // Detector address mask.
    input  wire logic                   det_level_i, // Trigger level.
    input  wire logic                   or_en_i,     // OR path enable.
    input  wire logic [EVT_N-1:0]       or_sel_i,    // OR event select.
    input  wire logic                   oth_en_i,    // Other path enable.
    input  wire mode_t                  oth_mode_i,  // Other path mode.
    input  wire logic [EVT_N-1:0]       and_sel_i,   // AND event select.
    input  wire logic [IDX_W-1:0]       sub_evt_i,   // Subroutine event.
    input  wire logic [ADDR_W-1:0]      sub_lo_i,    // Range low address.
    input  wire logic [ADDR_W-1:0]      sub_hi_i,    // Range high address.
    input  wire logic [SEQ_N*IDX_W-1:0] seq_evt_i,   // Step events, step 0 low.
    input  wire logic [1:0]             seq_last_i,  // Index of last step.
    input  wire logic [PATH_N*PATH_W-1:0] path_i,    // Transition paths.
    input  wire logic                   rp_en_i,     // Reset point enable.
    input  wire logic [IDX_W-1:0]       rp_evt_i,    // Reset point event.
    input  wire logic [EXC_N-1:0]       exc_sel_i,   // Exception select.
    input  wire logic [DELAY_W-1:0]     delay_i,     // Break delay.
    input  wire logic                   apply_i,     // Commit settings.
    input  wire logic                   resume_i,    // Release the halt.
    output logic                        halt_o,      // Stop user program.
    output logic                        pend_o,      // Break delay running.
    output logic [1:0]                  step_o       // Sequencer step.
);
    logic                   or_en_a;
    logic [EVT_N-1:0]       or_sel_a;
    logic                   oth_en_a;
    mode_t                  mode_a;
    logic [EVT_N-1:0]       and_sel_a;
    logic [IDX_W-1:0]       sub_evt_a;
    logic [ADDR_W-1:0]      sub_lo_a;
    logic [ADDR_W-1:0]      sub_hi_a;
    logic [SEQ_N*IDX_W-1:0] seq_evt_a;
    logic [1:0]             seq_last_a;
    logic [PATH_N*PATH_W-1:0] path_a;
    logic                   rp_en_a;
    logic [IDX_W-1:0]       rp_evt_a;
    logic [EXC_N-1:0]       exc_sel_a;
    logic [DELAY_W-1:0]     delay_a;
    logic [EVT_N-1:0]       hit;
    logic                   hit_vld;
    logic [ADDR_W-1:0]      pc_q;
    logic [EVT_N-1:0]       acc_q;
    logic [1:0]             st_q;
    logic [1:0]             st_d;
    logic                   stt_fin;
    logic                   oth_fire;
    logic                   or_fire;
    logic                   exc_fire;
    logic                   fire;
    logic                   idle;
    logic                   pend_q;
    logic                   halt_q;
    logic [DELAY_W-1:0]     cnt_q;

    function automatic logic evt(input logic [EVT_N-1:0] h, input logic [IDX_W-1:0] i);
        return h[i];
    endfunction

    evt_det_bank u_det (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .bus_cyc_i   (bus_cyc_i),
        .bus_fetch_i (bus_fetch_i),
        .bus_addr_i  (bus_addr_i),
        .int_ack_i   (int_ack_i),
        .trig_pin_i  (trig_pin_i),
        .det_we_i    (det_we_i),
        .det_idx_i   (det_idx_i),
        .det_kind_i  (det_kind_i),
        .det_addr_i  (det_addr_i),
        .det_mask_i  (det_mask_i),
        .det_level_i (det_level_i),
        .apply_i     (apply_i),
        .hit_o       (hit),
        .hit_vld_o   (hit_vld)
    );

    // Active settings change only on apply.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            or_en_a    <= OR_EN_RST;
            oth_en_a   <= OTH_EN_RST;
            delay_a    <= DELAY_RST;
            or_sel_a   <= '0;
            mode_a     <= M_ACC;
            and_sel_a  <= '0;
            sub_evt_a  <= '0;
            sub_lo_a   <= '0;
            sub_hi_a   <= '0;
            seq_evt_a  <= '0;
            seq_last_a <= '0;
            path_a     <= '0;
            rp_en_a    <= 1'b0;
            rp_evt_a   <= '0;
            exc_sel_a  <= '0;
        end else if (apply_i) begin
            or_en_a    <= or_en_i;
            oth_en_a   <= oth_en_i;
            delay_a    <= delay_i;
            or_sel_a   <= or_sel_i;
            mode_a     <= oth_mode_i;
            and_sel_a  <= and_sel_i;
            sub_evt_a  <= sub_evt_i;
            sub_lo_a   <= sub_lo_i;
            sub_hi_a   <= sub_hi_i;
            seq_evt_a  <= seq_evt_i;
            seq_last_a <= seq_last_i;
            path_a     <= path_i;
            rp_en_a    <= rp_en_i;
            rp_evt_a   <= rp_evt_i;
            exc_sel_a  <= exc_sel_i;
        end
    end

    // Fetch address of the cycle whose hits are now visible.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pc_q <= '0;
        end else if (bus_cyc_i && bus_fetch_i) begin
            pc_q <= bus_addr_i;
        end
    end

    assign idle     = !pend_q && !halt_q;
    assign or_fire  = or_en_a && hit_vld && |(hit & or_sel_a);
    assign exc_fire = |(exc_i & exc_sel_a);

    // Sequencer next step for sequential and state-transition modes.
    always_comb begin
        st_d    = st_q;
        stt_fin = 1'b0;
        if (mode_a == M_SEQ) begin
            if (evt(hit, seq_evt_a[st_q*IDX_W +: IDX_W])) begin
                st_d = (st_q == seq_last_a) ? ST_INIT : st_q + 2'h1;
            end
        end else begin
            for (int p = PATH_N - 1; p >= 0; p--) begin
                if (path_a[p*PATH_W+P_EN] && path_a[p*PATH_W+P_FROM +: 2] == st_q
                    && evt(hit, path_a[p*PATH_W+P_EVT +: IDX_W])) begin
                    st_d = path_a[p*PATH_W+P_TO +: 2];
                end
            end
            // Reaching the final state fires once and restarts from the first state.
            stt_fin = st_d == ST_FINAL;
            if (stt_fin) begin
                st_d = ST_INIT;
            end
        end
        if (rp_en_a && evt(hit, rp_evt_a)) begin
            st_d = ST_INIT;
        end
    end

    always_comb begin
        oth_fire = 1'b0;
        if (oth_en_a && hit_vld) begin
            case (mode_a)
                M_ACC:   oth_fire = and_sel_a != '0
                                    && ((acc_q | hit) & and_sel_a) == and_sel_a;
                M_SIM:   oth_fire = and_sel_a != '0 && (hit & and_sel_a) == and_sel_a;
                M_SUB:   oth_fire = evt(hit, sub_evt_a) && pc_q >= sub_lo_a
                                    && pc_q <= sub_hi_a;
                M_SEQ:   oth_fire = !(rp_en_a && evt(hit, rp_evt_a)) && st_q == seq_last_a
                                    && evt(hit, seq_evt_a[st_q*IDX_W +: IDX_W]);
                M_STT:   oth_fire = !(rp_en_a && evt(hit, rp_evt_a)) && stt_fin;
                default: oth_fire = 1'b0;
            endcase
        end
    end

    assign fire = idle && (or_fire || oth_fire || exc_fire);

    // Progress of the AND and sequencer modes; cleared on apply or resume.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || apply_i || resume_i) begin
            acc_q <= '0;
            st_q  <= ST_INIT;
        end else if (oth_en_a && hit_vld && idle) begin
            acc_q <= (fire || mode_a != M_ACC) ? '0 : (acc_q | (hit & and_sel_a));
            st_q  <= (mode_a == M_SEQ || mode_a == M_STT) ? st_d : ST_INIT;
        end
    end

    // Delay counter in bus cycles, then a held halt until resume.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || resume_i) begin
            pend_q <= 1'b0;
            halt_q <= 1'b0;
            cnt_q  <= DELAY_RST;
        end else if (fire) begin
            pend_q <= delay_a != DELAY_RST;
            halt_q <= delay_a == DELAY_RST;
            cnt_q  <= delay_a;
        end else if (pend_q && bus_cyc_i) begin
            cnt_q  <= cnt_q - DELAY_ONE;
            if (cnt_q == DELAY_ONE) begin
                pend_q <= 1'b0;
                halt_q <= 1'b1;
            end
        end
    end

    assign halt_o = halt_q;
    assign pend_o = pend_q;
    assign step_o = st_q;

    property p_imm;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i)
        fire && delay_a == DELAY_RST |=> halt_q && !pend_q;
    endproperty
    a_imm: assert property (p_imm) else $error("zero delay did not halt at once");

    property p_delay;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i)
        pend_q && bus_cyc_i && cnt_q == DELAY_ONE |=> halt_q ##1 halt_q;
    endproperty
    a_delay: assert property (p_delay) else $error("halt not reached after delay");

    property p_rst_delay;
        @(posedge clk_i) $fell(sys_rst_i) |-> delay_a == DELAY_RST && or_en_a && !oth_en_a;
    endproperty
    a_rst_delay: assert property (p_rst_delay) else $error("bad settings after reset");

    property p_or;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i)
        idle && hit_vld && or_en_a && |(hit & or_sel_a) |=> pend_q || halt_q;
    endproperty
    a_or: assert property (p_or) else $error("OR event did not break");

    property p_none;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i)
        idle && !or_en_a && !oth_en_a && exc_sel_a == '0 |=> !pend_q && !halt_q;
    endproperty
    a_none: assert property (p_none) else $error("break with every path off");

    property p_sim;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i)
        idle && hit_vld && oth_en_a && mode_a == M_SIM && and_sel_a != '0
        && (hit & and_sel_a) == and_sel_a |=> pend_q || halt_q;
    endproperty
    a_sim: assert property (p_sim) else $error("simultaneous AND missed");

    property p_acc;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i || apply_i)
        oth_en_a && mode_a == M_ACC && idle && hit_vld && (hit & and_sel_a) != '0
        && !fire |=> (acc_q & $past(hit & and_sel_a)) == $past(hit & and_sel_a);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulated event lost");

    property p_exc;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i)
        idle && (exc_i & exc_sel_a) != '0 |=> pend_q || halt_q;
    endproperty
    a_exc: assert property (p_exc) else $error("exception did not break");

    property p_rp;
        @(posedge clk_i) disable iff (sys_rst_i || resume_i || apply_i)
        idle && hit_vld && oth_en_a && rp_en_a && evt(hit, rp_evt_a) |=> st_q == ST_INIT;
    endproperty
    a_rp: assert property (p_rp) else $error("reset point ignored");

    property p_st;
        @(posedge clk_i) disable iff (sys_rst_i)
        mode_a == M_STT |-> st_q != 2'h3 && st_q != ST_FINAL;
    endproperty
    a_st: assert property (p_st) else $error("illegal sequencer state");

    property p_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        !apply_i |=> $stable(delay_a) && $stable(mode_a) && $stable(or_sel_a);
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed without apply");

    c_or:    cover property (@(posedge clk_i) or_fire && idle);
    c_seq:   cover property (@(posedge clk_i) oth_fire && mode_a == M_SEQ);
    c_stt:   cover property (@(posedge clk_i) oth_fire && mode_a == M_STT);
    c_delay: cover property (@(posedge clk_i) pend_q ##1 halt_q);
endmodule

/* File: brk_pkg.sv */
// Shared constants and types for the hardware break condition unit.
// Assumes one bus-cycle clock domain and a synchronous active-high reset.
package brk_pkg;
    localparam int EVT_N    = 16;
    localparam int IDX_W    = 4;
    localparam int ADDR_W   = 24;
    localparam int DELAY_W  = 16;
    localparam int EXC_N    = 8;
    localparam int SEQ_N    = 4;
    localparam int PATH_N   = 9;
    localparam int PATH_W   = 9;
    localparam logic [DELAY_W-1:0] DELAY_RST  = 16'h0000;
    localparam logic [DELAY_W-1:0] DELAY_ONE  = 16'h0001;
    localparam logic               OR_EN_RST  = 1'b1;
    localparam logic               OTH_EN_RST = 1'b0;
    localparam logic [1:0]         ST_INIT    = 2'h0;
    localparam logic [1:0]         ST_FINAL   = 2'h2;
    // Path field layout: enable, from state, to state, event index.
    localparam int P_EN   = 8;
    localparam int P_FROM = 6;
    localparam int P_TO   = 4;
    localparam int P_EVT  = 0;
    // Exception select bit positions.
    localparam int EX_PROT  = 0;
    localparam int EX_UNINI = 1;
    localparam int EX_STACK = 2;
    localparam int EX_PERF  = 3;
    localparam int EX_PROF  = 4;
    localparam int EX_TRACE = 5;
    localparam int EX_TASK  = 6;
    localparam int EX_DISP  = 7;
    typedef enum logic [1:0] {
        K_FETCH = 2'h0,
        K_DATA  = 2'h1,
        K_INT   = 2'h2,
        K_TRIG  = 2'h3
    } kind_t;
    typedef enum logic [2:0] {
        M_ACC = 3'h0,
        M_SIM = 3'h1,
        M_SUB = 3'h3,
        M_SEQ = 3'h2,
        M_STT = 3'h6
    } mode_t;
endpackage

/* File: evt_det_bank.sv */
// Bank of event detectors that compare each bus cycle against stored criteria.
// Assumes criteria are written one detector at a time and committed by apply_i.
module evt_det_bank
    import brk_pkg::*;
(
    input  wire logic              clk_i,       // Bus-cycle clock.
    input  wire logic              sys_rst_i,   // Synchronous reset.
    input  wire logic              bus_cyc_i,   // Valid bus cycle.
    input  wire logic              bus_fetch_i, // Cycle is an instruction fetch.
    input  wire logic [ADDR_W-1:0] bus_addr_i,  // Cycle address.
    input  wire logic              int_ack_i,   // Interrupt acknowledge cycle.
    input  wire logic              trig_pin_i,  // External trigger pin.
    input  wire logic              det_we_i,    // Write staged criteria.
    input  wire logic [IDX_W-1:0]  det_idx_i,   // Detector index.
    input  wire kind_t             det_kind_i,  // Detector kind.
    input  wire logic [ADDR_W-1:0] det_addr_i,  // Compare address.
    input  wire logic [ADDR_W-1:0] det_mask_i,  // Address bits to compare.
    input  wire logic              det_level_i, // Trigger level to match.
    input  wire logic              apply_i,     // Commit staged criteria.
    output logic [EVT_N-1:0]       hit_o,       // Detector hits.
    output logic                   hit_vld_o    // Hits belong to a bus cycle.
);
    kind_t             kind_s [EVT_N];
    kind_t             kind_a [EVT_N];
    logic [ADDR_W-1:0] addr_s [EVT_N];
    logic [ADDR_W-1:0] addr_a [EVT_N];
    logic [ADDR_W-1:0] mask_s [EVT_N];
    logic [ADDR_W-1:0] mask_a [EVT_N];
    logic [EVT_N-1:0]  lvl_s;
    logic [EVT_N-1:0]  lvl_a;
    logic              trig_m_q;
    logic              trig_q;
    logic [EVT_N-1:0]  hit_d;

    always_ff @(posedge clk_i) begin
        trig_m_q <= trig_pin_i;
        trig_q   <= trig_m_q;
    end

    // Only sixteen detectors exist; the index cannot address more.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < EVT_N; i++) begin
                kind_s[i] <= K_FETCH;
                addr_s[i] <= '0;
                mask_s[i] <= '0;
            end
            lvl_s <= '0;
        end else if (det_we_i) begin
            kind_s[det_idx_i] <= det_kind_i;
            addr_s[det_idx_i] <= det_addr_i;
            mask_s[det_idx_i] <= det_mask_i;
            lvl_s[det_idx_i]  <= det_level_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < EVT_N; i++) begin
                kind_a[i] <= K_FETCH;
                addr_a[i] <= '0;
                mask_a[i] <= '0;
            end
            lvl_a <= '0;
        end else if (apply_i) begin
            kind_a <= kind_s;
            addr_a <= addr_s;
            mask_a <= mask_s;
            lvl_a  <= lvl_s;
        end
    end

    always_comb begin
        logic am;
        am = 1'b0;
        for (int i = 0; i < EVT_N; i++) begin
            am = ((bus_addr_i ^ addr_a[i]) & mask_a[i]) == '0;
            case (kind_a[i])
                K_FETCH: hit_d[i] = bus_fetch_i && am;
                K_DATA:  hit_d[i] = !bus_fetch_i && !int_ack_i && am;
                K_INT:   hit_d[i] = int_ack_i;
                K_TRIG:  hit_d[i] = trig_q == lvl_a[i];
                default: hit_d[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hit_o     <= '0;
            hit_vld_o <= 1'b0;
        end else begin
            hit_o     <= bus_cyc_i ? hit_d : '0;
            hit_vld_o <= bus_cyc_i;
        end
    end
endmodule

/* File: tgt_bus_model.sv */
// Behavioural model of the monitored target bus that feeds the break unit.
// Assumes the bench calls cycle() from clock-edge-aligned code.
module tgt_bus_model
    import brk_pkg::*;
(
    input  wire logic        clk_i,       // Bus-cycle clock.
    output logic              bus_cyc_o,   // Valid bus cycle.
    output logic              bus_fetch_o, // Instruction fetch cycle.
    output logic [ADDR_W-1:0] bus_addr_o   // Cycle address.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_cyc_o = 1'b0;
        bus_fetch_o = 1'b0;
        bus_addr_o = '0;
    end
    // One fetch cycle after gap + 1 idle clocks; idle lines flip so stale values never match.
    task automatic cycle(input logic [ADDR_W-1:0] a, input int gap);
        repeat (gap + 1) @(posedge clk_i);
        bus_cyc_o <= 1'b1;
        bus_fetch_o <= 1'b1;
        bus_addr_o <= a;
        @(posedge clk_i);
        bus_cyc_o <= 1'b0;
        bus_fetch_o <= 1'b0;
        bus_addr_o <= ~a;
    endtask
endmodule

/* File: hw_break_unit_test.sv */
// Self-checking bench for the hardware break unit.
// Assumes the target bus model and the unit share one 100 MHz clock.
module hw_break_unit_test
    import brk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk_i, sys_rst_i, bus_cyc, bus_fetch, det_we, det_level;
    logic                     int_ack, trig, or_en, oth_en, rp_en, apply, resume, halt, pend;
    logic [ADDR_W-1:0]        bus_addr, det_addr, det_mask, sub_lo, sub_hi;
    logic [IDX_W-1:0]         det_idx, sub_evt, rp_evt;
    logic [EVT_N-1:0]         or_sel, and_sel;
    logic [EXC_N-1:0]         exc, exc_sel;
    logic [SEQ_N*IDX_W-1:0]   seq_evt;
    logic [PATH_N*PATH_W-1:0] path;
    logic [DELAY_W-1:0]       delay;
    logic [1:0]               seq_last, step;
    kind_t                    det_kind;
    mode_t                    oth_mode;
    int                       err_total, num_checks;
    tgt_bus_model bus (.clk_i(clk_i), .bus_cyc_o(bus_cyc), .bus_fetch_o(bus_fetch),
        .bus_addr_o(bus_addr));
    hw_break_unit dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_cyc_i(bus_cyc),
        .bus_fetch_i(bus_fetch), .bus_addr_i(bus_addr), .int_ack_i(int_ack), .trig_pin_i(trig),
        .exc_i(exc), .det_we_i(det_we), .det_idx_i(det_idx), .det_kind_i(det_kind),
        .det_addr_i(det_addr), .det_mask_i(det_mask), .det_level_i(det_level),
        .or_en_i(or_en), .or_sel_i(or_sel), .oth_en_i(oth_en), .oth_mode_i(oth_mode),
        .and_sel_i(and_sel), .sub_evt_i(sub_evt), .sub_lo_i(sub_lo), .sub_hi_i(sub_hi),
        .seq_evt_i(seq_evt), .seq_last_i(seq_last), .path_i(path), .rp_en_i(rp_en),
        .rp_evt_i(rp_evt), .exc_sel_i(exc_sel), .delay_i(delay), .apply_i(apply),
        .resume_i(resume), .halt_o(halt), .pend_o(pend), .step_o(step));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string w);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %b", $time, w, got);
        end
    endtask
    task automatic look(input logic h, input logic p, input string w);
        repeat (2) @(posedge clk_i);
        #1;
        chk({1'b0, halt}, {1'b0, h}, {w, " halt"});
        chk({1'b0, pend}, {1'b0, p}, {w, " pend"});
        @(posedge clk_i);
    endtask
    task automatic det(input logic [3:0] i, input logic [23:0] a, input logic [23:0] m);
        @(posedge clk_i);
        det_we <= 1'b1;
        det_idx <= i;
        det_addr <= a;
        det_mask <= m;
        @(posedge clk_i);
        det_we <= 1'b0;
    endtask
    task automatic commit();
        @(posedge clk_i);
        apply <= 1'b1;
        @(posedge clk_i);
        apply <= 1'b0;
    endtask
    task automatic release_halt();
        @(posedge clk_i);
        resume <= 1'b1;
        @(posedge clk_i);
        resume <= 1'b0;
    endtask
    task automatic t_or();
        det(4'h2, 24'h001234, 24'hffffff);
        or_sel <= 16'h0004;
        bus.cycle(24'h001234, 0);
        look(1'b0, 1'b0, "unapplied");
        commit();
        bus.cycle(24'h001235, 0);
        look(1'b0, 1'b0, "addr miss");
        bus.cycle(24'h001234, 0);
        look(1'b1, 1'b0, "or hit");
        release_halt();
        or_en <= 1'b0;
        commit();
        bus.cycle(24'h001234, 0);
        look(1'b0, 1'b0, "or off");
        or_en <= 1'b1;
        $display("test or done");
    endtask
    task automatic t_delay();
        delay <= 16'h0002;
        commit();
        bus.cycle(24'h001234, 0);
        look(1'b0, 1'b1, "delay start");
        bus.cycle(24'h002000, 3);
        look(1'b0, 1'b1, "delay one");
        bus.cycle(24'h002000, 0);
        look(1'b1, 1'b0, "delay end");
        release_halt();
        look(1'b0, 1'b0, "resumed");
        delay <= 16'h0000;
        $display("test delay done");
    endtask
    task automatic t_exc();
        for (int i = 0; i < EXC_N; i++) begin
            exc_sel <= 8'h01 << i;
            commit();
            exc <= ~(8'h01 << i);
            @(posedge clk_i);
            exc <= 8'h00;
            look(1'b0, 1'b0, "exc other");
            exc <= 8'h01 << i;
            @(posedge clk_i);
            exc <= 8'h00;
            look(1'b1, 1'b0, "exc sel");
            release_halt();
        end
        exc_sel <= 8'h00;
        $display("test exceptions done");
    endtask
    task automatic mode_run(input mode_t m, input logic [23:0] a0, a1, input string w);
        oth_mode <= m;
        commit();
        bus.cycle(a0, 0);
        look(1'b0, 1'b0, w);
        bus.cycle(a1, 0);
        look(1'b1, 1'b0, w);
        release_halt();
    endtask
    task automatic t_modes();
        det(4'h1, 24'h002000, 24'hffffff);
        det(4'h3, 24'h000000, 24'h000000);
        det(4'h4, 24'h003000, 24'hffffff);
        or_sel <= 16'h0000;
        oth_en <= 1'b1;
        and_sel <= 16'h0006;
        mode_run(M_ACC, 24'h001234, 24'h002000, "acc");
        and_sel <= 16'h000c;
        mode_run(M_SIM, 24'h002000, 24'h001234, "sim");
        mode_run(M_SUB, 24'h002000, 24'h001234, "sub");
        mode_run(M_STT, 24'h001234, 24'h002000, "stt");
        oth_mode <= M_SEQ;
        commit();
        bus.cycle(24'h002000, 0);
        look(1'b0, 1'b0, "seq a");
        #1 chk(step, 2'h1, "seq step");
        bus.cycle(24'h003000, 0);
        look(1'b0, 1'b0, "seq rp");
        #1 chk(step, 2'h0, "seq rp step");
        bus.cycle(24'h002000, 0);
        look(1'b0, 1'b0, "seq b");
        bus.cycle(24'h001234, 0);
        look(1'b1, 1'b0, "seq fire");
        release_halt();
        $display("test modes done");
    endtask
    task automatic t_kinds();
        oth_en <= 1'b0;
        det_kind <= K_TRIG;
        det_level <= 1'b1;
        det(4'h5, 24'h000000, 24'h000000);
        det_kind <= K_INT;
        det(4'h6, 24'h000000, 24'h000000);
        det_kind <= K_FETCH;
        or_sel <= 16'h0020;
        commit();
        bus.cycle(24'h001234, 2);
        look(1'b0, 1'b0, "trig low");
        trig <= 1'b1;
        bus.cycle(24'h001234, 2);
        look(1'b1, 1'b0, "trig high");
        release_halt();
        trig <= 1'b0;
        or_sel <= 16'h0040;
        commit();
        bus.cycle(24'h001234, 2);
        look(1'b0, 1'b0, "no int");
        int_ack <= 1'b1;
        bus.cycle(24'h001234, 0);
        int_ack <= 1'b0;
        look(1'b1, 1'b0, "int ack");
        release_halt();
        $display("test kinds done");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        $display("unexpected at %0t: run timed out", $time);
        tally_and_finish();
    end
    initial begin
        {sys_rst_i, or_en} = 2'b11;
        {det_we, det_level, int_ack, trig, oth_en, rp_en, apply, resume} = 8'h00;
        {det_addr, det_mask, det_idx} = '0;
        {or_sel, and_sel, exc, exc_sel, delay, path} = '0;
        det_kind = K_FETCH;
        oth_mode = M_ACC;
        sub_evt = 4'h3;
        sub_lo = 24'h001234;
        sub_hi = 24'h001234;
        seq_evt = 16'h0021;
        seq_last = 2'h1;
        rp_en = 1'b1;
        rp_evt = 4'h4;
        path[8:0] = 9'h121;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        look(1'b0, 1'b0, "reset");
        #1 chk(step, 2'h0, "reset step");
        t_or();
        t_delay();
        t_exc();
        t_modes();
        t_kinds();
        tally_and_finish();
    end
endmodule
